// ---- spbc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module spbc_host (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic [31:0]      haddr = 32'h0,
    output logic [1:0]       htrans = 2'h0,
    output logic             hwrite = 1'b0,
    output logic [31:0]      hwdata = 32'h0
);
    logic [31:0] exp_q[$], rdv; // Notes of expected reads, oldest first, and the last read word.
    event        done;          // Fires once a read has been taken.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        {htrans, hwrite, haddr} <= {2'h2, w, 24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        rdv = hrdata;
        if (!w) -> done;
    endtask : xfer
endmodule : spbc_host
`default_nettype wire

// ---- spbc_pkg.sv ----
`default_nettype none

// Shared constants for the speech power and bank control block.
package spbc_pkg;

    // ROM geometry for the largest part: 16 Mbit, byte addressed.
    localparam int ADDR_W        = 21;                  // ROM byte address width.
    localparam int PHRASE_W      = 10;                  // Phrase number width inside one bank.
    localparam int GPHRASE_W     = 12;                  // Phrase number width across four banks.
    localparam logic [20:0] ROM_LAST    = 21'h1FFFFF;   // Last ROM byte.
    localparam logic [20:0] HALF_SIZE   = 21'h100000;   // Base of the upper half.
    localparam logic [20:0] HALF_MASK   = 21'h0FFFFF;   // Offset mask inside a half.
    localparam logic [20:0] QUART_MASK  = 21'h07FFFF;   // Offset mask inside a quarter.
    localparam int QUART_SHIFT   = 19;                  // Bit position of the quarter index.

    // Command bytes and fields.
    localparam logic [7:0] PUP_MASK     = 8'hFC;        // Upper six bits of power-up must be zero.
    localparam logic [7:0] POWER_DOWN_CMD_CODE    = 8'h20;        // Power-down command byte.
    localparam logic [7:0] ANALOG_MODE_CMD_CODE   = 8'h04;        // Analog-mode command, first byte.
    localparam int SPEN_BIT      = 1;                   // Speaker enable bit of the analog-mode second byte.

    // Bank-count field encodings.
    localparam logic [1:0] BANKS_ONE    = 2'h0;         // Whole memory.
    localparam logic [1:0] BANKS_TWO    = 2'h1;         // Two halves by the low select pin.

    // Register byte offsets on the bus.
    localparam logic [7:0] REG_CMD      = 8'h00;        // Write: command byte. Read: last command byte.
    localparam logic [7:0] REG_STATUS   = 8'h04;        // Read: power state and flags.
    localparam logic [7:0] REG_ADDR     = 8'h08;        // Read: last resolved ROM address.

    // Status register field positions.
    localparam int ST_STATE_LSB  = 0;                   // Three-bit power state.
    localparam int ST_BANKS_LSB  = 4;                   // Two-bit bank count.
    localparam int ST_SEL_LSB    = 6;                   // Synchronised select pins.
    localparam int ST_READY_BIT  = 8;                   // Command ready flag.
    localparam int ST_BUSY_BIT   = 9;                   // Command busy, active low.
    localparam int ST_AMP_BIT    = 10;                  // Speaker amplifier powered.

    // Timing: times in ns, counts derived at 100 MHz.
    localparam int CLK_MHZ       = 100;                 // Clock rate.
    localparam int T_STAB_NS     = 10000;               // Oscillator stabilisation time.
    localparam int T_CMD_NS      = 1000;                // Command processing time.
    localparam int STAB_CYC      = (T_STAB_NS * CLK_MHZ + 999) / 1000;
    localparam int CMD_CYC       = (T_CMD_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W         = 16;                  // Width of the shared timer.

    // Power and command states.
    typedef enum logic [2:0] {
        SPBC_PDOWN  = 3'b000,                           // Power-down.
        SPBC_STAB   = 3'b001,                           // Oscillator stabilising.
        SPBC_WAIT   = 3'b010,                           // Command waiting.
        SPBC_PROC   = 3'b011,                           // Processing an ordinary command.
        SPBC_PDPROC = 3'b100                            // Processing power-down.
    } spbc_state_t;

endpackage : spbc_pkg

`default_nettype wire

// ---- spbc_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module spbc_tb_top;
    logic clk = 0, reset_n = 0, pin_n = 1, sl = 0, sh = 0, play = 0, req = 0, hwrite, hready;
    logic [9:0]  pnum = 10'h0;          // Phrase number inside the bank.
    logic [31:0] ea;                    // Expected resolved address word.
    wire  [7:0]  pw;                    // Power pins and flags, regulator first, playback busy last.
    wire  [20:0] raddr;                 // Resolved ROM address.
    wire  [11:0] pglob;                 // Phrase number across banks.
    wire         avld, hresp_w;         // Address strobe and bus response.
    logic [31:0] haddr, hwdata, hrdata; // Bus between host model and block.
    logic [20:0] off = 21'h0;           // Byte offset inside the bank.
    logic [1:0]  htrans;
    int          mismatches = 0, comparisons = 0;
    always #5 clk = ~clk;
    spbc_top u_spbc_top (.clk(clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp_w),
        .hrdata(hrdata), .reset_in_low(pin_n), .bank_select_lo(sl), .bank_select_hi(sh), .phrase_num(pnum),
        .playback_active(play), .phrase_req(req), .phrase_offset(off), .rom_addr(raddr),
        .phrase_global(pglob), .rom_addr_valid(avld), .cmd_busy_low(pw[1]), .cmd_ready_flag(pw[2]),
        .playback_busy_low(pw[0]), .regulator_on(pw[7]), .signal_ground_on(pw[5]), .speaker_pos_drive(pw[4]),
        .speaker_neg_out(pw[3]), .speaker_neg_oe(pw[6]));
    spbc_host u_spbc_host (.clk(clk), .hready(hready), .hrdata(hrdata), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) $display("[ERR] %s expected %h seen %h", nm, e, s);
        mismatches += int'(s !== e);
    endtask : chk
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // Watcher: each completed read is compared with the oldest note.
    always @(u_spbc_host.done) chk("read", u_spbc_host.rdv, u_spbc_host.exp_q.pop_front());
    initial begin
        #100000 mismatches++;
        close_out();
    end
    // Each pass powers up with one bank count, looks up a phrase, then powers down.
    initial begin
        void'($urandom(42));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            play <= 1'b1;
            u_spbc_host.xfer(1'b1, 8'h00, 32'h20);
            u_spbc_host.xfer(1'b1, 8'h00, {30'h0, k[1:0]});
            u_spbc_host.xfer(1'b1, 8'h00, {30'h0, ~k[1:0]});
            repeat (1010) @(posedge clk);
            u_spbc_host.xfer(1'b1, 8'h00, 32'h20);
            u_spbc_host.xfer(1'b1, 8'h00, {30'h0, ~k[1:0]});
            u_spbc_host.xfer(1'b0, 8'h04, {22'h0, 2'h3, sh, sl, k[1:0], 4'h2});
            u_spbc_host.xfer(1'b1, 8'h00, 32'h04);
            repeat (110) @(posedge clk);
            u_spbc_host.xfer(1'b1, 8'h00, 32'h02);
            repeat (110) @(posedge clk);
            chk("amp", {24'h0, pw}, 32'hF6);
            {play, sh, sl, off} <= {1'b0, 23'($urandom)};
            pnum <= 10'($urandom);
            repeat (6) @(posedge clk);
            req <= 1'b1;
            @(posedge clk) req <= 1'b0;
            ea = {11'h0, k == 0 ? off : k == 1 ? {sl, off[19:0]} : {sh, sl, off[18:0]}};
            @(posedge clk);
            chk("valid", {31'h0, avld}, 32'h1);
            chk("rom_addr", {11'h0, raddr}, ea);
            chk("phrase", {20'h0, pglob}, {20'h0, k == 0 ? 2'h0 : k == 1 ? {1'b0, sl} : {sh, sl}, pnum});
            u_spbc_host.xfer(1'b0, 8'h08, ea);
            u_spbc_host.xfer(1'b1, 8'h00, 32'h20);
            repeat (50) @(posedge clk);
            chk("pd_hold", {24'h0, pw}, 32'hF1);
            repeat (60) @(posedge clk);
            chk("power", {24'h0, pw}, 32'h03);
            u_spbc_host.xfer(1'b0, 8'h04, {22'h0, 2'h2, sh, sl, 6'h0});
        end
        u_spbc_host.xfer(1'b1, 8'h00, 32'h1);
        pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk("pin_reset", {23'h0, hresp_w, pw}, 32'h03);
        u_spbc_host.xfer(1'b0, 8'h04, {22'h0, 2'h2, sh, sl, 6'h0});
        @(posedge clk) close_out();
    end
endmodule : spbc_tb_top
`default_nettype wire

// ---- spbc_top.sv ----
// Summary of operation
// (R1) Up to four banks of 1024 phrases.
// (R2) Host sets bank count before any playback.
// (R3) One bank: select pins low map whole ROM.
// (R4) Two banks: low select picks ROM half.
// (R5) Four banks: both selects pick ROM quarter.
// (R6) Power-up byte carries bank count, enters waiting.
// (R7) Field 00 whole, 01 halves, 10 quarters.
// (R8) Field 11 behaves like four areas.
// (R9) Power-up honoured only in power-down state.
// (R10) Power-down at reset, pin low, after command.
// (R11) Commands during stabilisation are discarded.
// (R12) Reset pin low forces power-down immediately.
// (R13) Power-up leaves speaker amplifier off.
// (R14) Power-down byte honoured only while idle waiting.
// (R15) Power-down returns all settings to initial values.
// (R16) Host never powers down during playback.
// (R17) Host resumes: power-up, analog mode, play.
// (R18) After processing time stop regulator and amplifier.
// (R19) Power-down holds analog outputs grounded, negative floating.
// (R20) Host lowers volumes when mixing clips.
// (R21) Ready low while processing; busy low playing.
// (R22) ROM address is bank base plus offset.
// (R23) Select pins sampled when lookup starts.
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module spbc_top (
    input  wire logic                  clk,               // 100 MHz master clock.
    input  wire logic                  reset_n,           // Asynchronous reset, active low.
    input  wire logic                  hsel,              // Bus slave select.
    input  wire logic [31:0]           haddr,             // Bus address.
    input  wire logic [1:0]            htrans,            // Bus transfer type.
    input  wire logic                  hwrite,            // Bus write.
    input  wire logic [2:0]            hsize,             // Bus transfer size.
    input  wire logic [31:0]           hwdata,            // Bus write data.
    input  wire logic                  hready,            // Bus ready in.
    output logic                       hreadyout,         // Bus ready out.
    output logic                       hresp,             // Bus response.
    output logic [31:0]                hrdata,            // Bus read data.
    input  wire logic                  reset_in_low,      // Reset pin, active low, asynchronous.
    input  wire logic                  bank_select_lo,    // Low bank-select pin.
    input  wire logic                  bank_select_hi,    // High bank-select pin.
    input  wire logic                  playback_active,   // Playback engine is playing.
    input  wire logic                  phrase_req,        // Start of a phrase address lookup.
    input  wire logic [9:0]            phrase_num,        // Phrase number inside the bank.
    input  wire logic [20:0]           phrase_offset,     // Byte offset inside the bank.
    output logic [20:0]                rom_addr,          // Resolved ROM address.
    output logic [11:0]                phrase_global,     // Phrase number across all banks.
    output logic                       rom_addr_valid,    // One-cycle pulse with a new address.
    output logic                       cmd_busy_low,      // Low while a command is processed.
    output logic                       cmd_ready_flag,    // High in the command waiting state.
    output logic                       playback_busy_low, // Low while playback runs.
    output logic                       regulator_on,      // Both regulator outputs powered.
    output logic                       signal_ground_on,  // Signal-ground reference driven.
    output logic                       speaker_pos_drive, // Positive speaker output active.
    output logic                       speaker_neg_out,   // Negative speaker output level.
    output logic                       speaker_neg_oe     // Negative speaker output enable.
);

    // Three-stage synchronisers for the asynchronous pins.
    logic [2:0]                rst_sync_r;            // Reset pin stages.
    logic [2:0]                sello_sync_r;          // Low select stages.
    logic [2:0]                selhi_sync_r;          // High select stages.
    logic                      pin_rst_r;             // Filtered reset pin, high means asserted.
    logic [1:0]                sel_r;                 // Filtered select pins.

    // Control state.
    spbc_pkg::spbc_state_t     state_r;               // Power and command state.
    logic [spbc_pkg::CNT_W-1:0] cnt_r;                // Shared timer.
    logic [1:0]                bank_cnt_r;            // Configured bank count.
    logic                      amp_r;                 // Speaker amplifier enable.
    logic                      analog_mode_cmd_pend_r;          // Second analog-mode byte expected.
    logic [7:0]                last_cmd_r;            // Last command byte written.

    // Bus data-phase state.
    logic                      dp_wr_r;               // Data phase is a write.
    logic [7:0]                dp_addr_r;             // Data phase register offset.

    // Command strobe derived from a bus write to the command register.
    logic                      cmd_valid;             // One-cycle command strobe.
    logic [7:0]                cmd_data;              // Command byte.
    logic                      timer_done;            // Timer reached its end.

    assign cmd_valid  = dp_wr_r && (dp_addr_r == spbc_pkg::REG_CMD);
    assign cmd_data   = hwdata[7:0];
    assign timer_done = (cnt_r == '0);

    // Bring the reset and select pins into the clock domain; a change counts once stages two and three agree.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r   <= 3'h0;
            sello_sync_r <= 3'h0;
            selhi_sync_r <= 3'h0;
        end else begin
            rst_sync_r   <= {rst_sync_r[1:0], reset_in_low};
            sello_sync_r <= {sello_sync_r[1:0], bank_select_lo};
            selhi_sync_r <= {selhi_sync_r[1:0], bank_select_hi};
        end
    end

    // Update the filtered levels only when the last two stages agree.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_rst_r <= 1'b1;
            sel_r     <= 2'h0;
        end else begin
            if (rst_sync_r[2] == rst_sync_r[1]) begin
                pin_rst_r <= ~rst_sync_r[2];
            end
            if (sello_sync_r[2] == sello_sync_r[1]) begin
                sel_r[0] <= sello_sync_r[2];
            end
            if (selhi_sync_r[2] == selhi_sync_r[1]) begin
                sel_r[1] <= selhi_sync_r[2];
            end
        end
    end

    // Power state machine with its timer and configuration.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r      <= spbc_pkg::SPBC_PDOWN;   // [R10]
            cnt_r        <= '0;
            bank_cnt_r   <= spbc_pkg::BANKS_ONE;
            amp_r        <= 1'b0;
            analog_mode_cmd_pend_r <= 1'b0;
        end else if (pin_rst_r) begin
            // The reset pin wins over everything, stabilisation included.
            state_r      <= spbc_pkg::SPBC_PDOWN;   // [R12] [R10]
            cnt_r        <= '0;
            bank_cnt_r   <= spbc_pkg::BANKS_ONE;
            amp_r        <= 1'b0;
            analog_mode_cmd_pend_r <= 1'b0;
        end else begin
            case (state_r)
                spbc_pkg::SPBC_PDOWN: begin
                    // Only a power-up byte leaves power-down; it keeps the amplifier off.
                    if (cmd_valid && ((cmd_data & spbc_pkg::PUP_MASK) == 8'h00)) begin
                        state_r    <= spbc_pkg::SPBC_STAB;            // [R6] [R13]
                        bank_cnt_r <= cmd_data[1:0];                 // [R7] [R8]
                        cnt_r      <= spbc_pkg::CNT_W'(spbc_pkg::STAB_CYC - 1);
                    end
                end
                spbc_pkg::SPBC_STAB: begin
                    // Regulator runs while the oscillator settles; commands are dropped.
                    if (timer_done) begin
                        state_r <= spbc_pkg::SPBC_WAIT;              // [R11]
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                spbc_pkg::SPBC_WAIT: begin
                    if (cmd_valid && analog_mode_cmd_pend_r) begin
                        // Second analog-mode byte: speaker enable is the only bit kept here.
                        amp_r        <= cmd_data[spbc_pkg::SPEN_BIT];   // [R13]
                        analog_mode_cmd_pend_r <= 1'b0;
                        state_r      <= spbc_pkg::SPBC_PROC;
                        cnt_r        <= spbc_pkg::CNT_W'(spbc_pkg::CMD_CYC - 1);
                    end else if (cmd_valid && (cmd_data == spbc_pkg::POWER_DOWN_CMD_CODE)) begin
                        // Power-down needs both ready and not playing.
                        if (!playback_active) begin
                            state_r <= spbc_pkg::SPBC_PDPROC;        // [R14]
                            cnt_r   <= spbc_pkg::CNT_W'(spbc_pkg::CMD_CYC - 1);
                        end
                    end else if (cmd_valid && ((cmd_data & spbc_pkg::PUP_MASK) == 8'h00)) begin
                        // A power-up byte outside power-down is disregarded.
                        state_r <= spbc_pkg::SPBC_WAIT;              // [R9]
                    end else if (cmd_valid) begin
                        // Any other command occupies the processor for one processing time.
                        analog_mode_cmd_pend_r <= (cmd_data == spbc_pkg::ANALOG_MODE_CMD_CODE);
                        state_r      <= spbc_pkg::SPBC_PROC;         // [R21]
                        cnt_r        <= spbc_pkg::CNT_W'(spbc_pkg::CMD_CYC - 1);
                    end
                end
                spbc_pkg::SPBC_PROC: begin
                    // Bytes arriving during processing are not taken.
                    if (timer_done) begin
                        state_r <= spbc_pkg::SPBC_WAIT;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                spbc_pkg::SPBC_PDPROC: begin
                    // After the processing time all settings return to their initial values.
                    if (timer_done) begin
                        state_r      <= spbc_pkg::SPBC_PDOWN;        // [R18] [R10]
                        bank_cnt_r   <= spbc_pkg::BANKS_ONE;         // [R15]
                        amp_r        <= 1'b0;                        // [R15]
                        analog_mode_cmd_pend_r <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= spbc_pkg::SPBC_PDOWN;
                end
            endcase
        end
    end

    // Resolve the phrase address; select pins are sampled at the lookup start only.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rom_addr       <= 21'h000000;
            phrase_global  <= 12'h000;
            rom_addr_valid <= 1'b0;
        end else begin
            rom_addr_valid <= phrase_req;                            // [R23]
            if (phrase_req) begin
                if (bank_cnt_r == spbc_pkg::BANKS_ONE) begin
                    // Whole ROM, select pins ignored.
                    rom_addr      <= phrase_offset & spbc_pkg::ROM_LAST;            // [R3] [R22]
                    phrase_global <= {2'h0, phrase_num};
                end else if (bank_cnt_r == spbc_pkg::BANKS_TWO) begin
                    // Low select pin picks the half.
                    rom_addr      <= (sel_r[0] ? spbc_pkg::HALF_SIZE : 21'h000000)
                                     | (phrase_offset & spbc_pkg::HALF_MASK);       // [R4] [R22]
                    phrase_global <= {1'b0, sel_r[0], phrase_num};
                end else begin
                    // Both pins pick the quarter; the prohibited code lands here too.
                    rom_addr      <= {sel_r, 19'h00000}
                                     | (phrase_offset & spbc_pkg::QUART_MASK);      // [R5] [R8] [R22]
                    phrase_global <= {sel_r, phrase_num};                           // [R1]
                end
            end
        end
    end

    // Flags and analog controls follow the power state.
    always_comb begin
        cmd_ready_flag    = (state_r == spbc_pkg::SPBC_WAIT);                      // [R21]
        cmd_busy_low      = !((state_r == spbc_pkg::SPBC_PROC) ||
                              (state_r == spbc_pkg::SPBC_PDPROC));                 // [R21]
        playback_busy_low = !playback_active;                                      // [R21]
        regulator_on      = !pin_rst_r && (state_r != spbc_pkg::SPBC_PDOWN);       // [R19] [R18]
        signal_ground_on  = regulator_on && amp_r;                                 // [R19]
        speaker_pos_drive = regulator_on && amp_r;                                 // [R19]
        speaker_neg_out   = 1'b0;
        // The negative output keeps driving through power-down processing and floats with the regulator.
        speaker_neg_oe    = regulator_on && amp_r;                                 // [R18] [R19]
    end

    // Bus address phase: capture the transfer, prepare read data for the data phase.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata    <= 32'h00000000;
        end else if (hready) begin
            dp_wr_r   <= hsel && htrans[1] && hwrite;
            dp_addr_r <= haddr[7:0];
            hrdata    <= 32'h00000000;
            if (hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    spbc_pkg::REG_CMD: begin
                        hrdata <= {24'h000000, last_cmd_r};
                    end
                    spbc_pkg::REG_STATUS: begin
                        hrdata[spbc_pkg::ST_STATE_LSB +: 3] <= state_r;
                        hrdata[spbc_pkg::ST_BANKS_LSB +: 2] <= bank_cnt_r;
                        hrdata[spbc_pkg::ST_SEL_LSB +: 2]   <= sel_r;
                        hrdata[spbc_pkg::ST_READY_BIT]      <= cmd_ready_flag;
                        hrdata[spbc_pkg::ST_BUSY_BIT]       <= cmd_busy_low;
                        hrdata[spbc_pkg::ST_AMP_BIT]        <= amp_r;
                    end
                    spbc_pkg::REG_ADDR: begin
                        hrdata <= {11'h000, rom_addr};
                    end
                    default: begin
                        hrdata <= 32'h00000000;   // Unmapped offsets read zero.
                    end
                endcase
            end
        end
    end

    // Remember the last command byte for read-back.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last_cmd_r <= 8'h00;
        end else if (cmd_valid) begin
            last_cmd_r <= cmd_data;
        end
    end

    // The slave never stalls and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Checks on the control behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    pup_take_a: assert property ( // [R6]
        (state_r == spbc_pkg::SPBC_PDOWN) && !pin_rst_r && cmd_valid && (cmd_data[7:2] == 6'h00)
        |=> (state_r == spbc_pkg::SPBC_STAB) && (bank_cnt_r == $past(cmd_data[1:0])))
        else $error("power-up byte not taken");

    pup_ignore_a: assert property ( // [R9]
        (state_r == spbc_pkg::SPBC_WAIT) && !pin_rst_r && !analog_mode_cmd_pend_r && cmd_valid
        && (cmd_data[7:2] == 6'h00)
        |=> (state_r == spbc_pkg::SPBC_WAIT) && $stable(bank_cnt_r))
        else $error("power-up byte acted on outside power-down");

    stab_drop_a: assert property ( // [R11]
        (state_r == spbc_pkg::SPBC_STAB) && cmd_valid
        |=> $stable(bank_cnt_r) && !amp_r && (state_r != spbc_pkg::SPBC_PROC))
        else $error("command acted on during stabilisation");

    pin_reset_a: assert property ( // [R12]
        pin_rst_r |=> (state_r == spbc_pkg::SPBC_PDOWN) && !regulator_on)
        else $error("reset pin did not force power-down");

    amp_off_a: assert property ( // [R13]
        (state_r == spbc_pkg::SPBC_STAB) |-> !amp_r && !speaker_neg_oe)
        else $error("amplifier powered by power-up");

    power_down_cmd_take_a: assert property ( // [R14]
        (state_r == spbc_pkg::SPBC_WAIT) && !pin_rst_r && !analog_mode_cmd_pend_r && cmd_valid
        && (cmd_data == spbc_pkg::POWER_DOWN_CMD_CODE) && !playback_active
        |=> (state_r == spbc_pkg::SPBC_PDPROC) && !cmd_busy_low ##1 !cmd_busy_low)
        else $error("power-down byte not taken");

    power_down_cmd_end_a: assert property ( // [R18]
        (state_r == spbc_pkg::SPBC_PDPROC) && timer_done && !pin_rst_r
        |=> (state_r == spbc_pkg::SPBC_PDOWN) && cmd_busy_low && !regulator_on)
        else $error("power-down not completed after processing");

    cfg_init_a: assert property ( // [R15]
        (state_r == spbc_pkg::SPBC_PDOWN) |-> (bank_cnt_r == spbc_pkg::BANKS_ONE) && !amp_r)
        else $error("settings survive power-down");

    pd_pins_a: assert property ( // [R19]
        (state_r == spbc_pkg::SPBC_PDOWN) || pin_rst_r
        |-> !regulator_on && !signal_ground_on && !speaker_pos_drive && !speaker_neg_oe)
        else $error("analog outputs active in power-down");

    quarter_addr_a: assert property ( // [R5]
        phrase_req && bank_cnt_r[1]
        |=> rom_addr_valid && (rom_addr[20:19] == $past(sel_r))
            && (rom_addr[18:0] == $past(phrase_offset[18:0])))
        else $error("quarter bank address wrong");

    half_addr_a: assert property ( // [R4]
        phrase_req && (bank_cnt_r == spbc_pkg::BANKS_TWO)
        |=> (rom_addr[20] == $past(sel_r[0])) && (rom_addr[19:0] == $past(phrase_offset[19:0])))
        else $error("half bank address wrong");

    ready_flag_a: assert property ( // [R21]
        (state_r == spbc_pkg::SPBC_PROC) |-> !cmd_ready_flag && !cmd_busy_low)
        else $error("ready flag high while processing");

endmodule : spbc_top

`default_nettype wire
